// ---- logic/wdrtc_top.sv ----
// Periodic interrupt timer, watchdog and clock monitor control with register port.
//
// Contract
// R1 - Periodic rate field selects divide 2^13 to 2^19
// R2 - Timeout sets flag bit 7, others zero
// R3 - Writing one clears the flag, zero keeps
// R4 - Interrupt requested while flag and enable set
// R5 - Monitor enable resets on slow clocks
// R6 - Force monitor write once normal, sticky
// R7 - Software clears monitor enable before stop
// R8 - Force monitor reset writable special only
// R9 - Force watchdog reset writable special only
// R10 - Reset disable blocks all system resets
// R11 - Watchdog divisor from 2^13 to 2^23
// R12 - Watchdog rate write once, resets to one
// R13 - Bypass keeps last two base stages only
// R14 - Software restarts with 55 then AA
// R15 - Timeout before restart pair resets
// R16 - Any other restart byte resets immediately
// R17 - Stop in wait halts both timers
// R18 - Accepted AA clears counter and disarms
// R19 - Reset disable set on special reset
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module wdrtc_top #(
  parameter logic [4:0] PERIODIC_BASE_SHIFT = 5'h0D,
  parameter logic [4:0] WATCHDOG_BASE_SHIFT = 5'h0D
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic special_mode_in,
  input wire logic wait_mode_in,
  input wire logic clock_fail_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  output logic irq_out,
  output logic watchdog_reset_out,
  output logic monitor_reset_out
);
  import wdrtc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic special_q;
  logic [2:0] periodic_rate_q;
  logic periodic_irq_enable_q;
  logic stop_in_wait_q;
  logic divider_bypass_q;
  logic periodic_ctrl_written_q;
  logic periodic_timeout_flag_q;
  logic clk_monitor_enable_q;
  logic force_monitor_enable_q;
  logic reset_disable_q;
  logic [2:0] watchdog_rate_q;
  logic watchdog_ctrl_written_q;
  logic armed_q;
  logic [WDRTC_EV_WIDTH-1:0] event_status_q;
  logic [WDRTC_EV_WIDTH-1:0] event_enable_q;
  logic [7:0] rd_data_q;
  logic watchdog_reset_q;
  logic monitor_reset_q;
  logic fail_meta_q;
  logic fail_sync_q;

  // ****************************************
  // Decode
  // ****************************************
  logic wr_periodic_ctrl;
  logic wr_periodic_flag;
  logic wr_watchdog_ctrl;
  logic wr_restart;
  logic wr_event_clear;
  logic wr_event_enable;
  logic halted;
  logic periodic_tick;
  logic watchdog_tick;
  logic watchdog_on;
  logic monitor_on;
  logic restart_ok;
  logic bad_restart;
  logic force_wd;
  logic force_mon;
  logic [4:0] periodic_shift;
  logic [4:0] watchdog_shift;
  logic [WDRTC_EV_WIDTH-1:0] event_set;

  // Address decode for writes; unmapped writes fall through and are dropped.
  always_comb begin
    wr_periodic_ctrl = 1'b0;
    wr_periodic_flag = 1'b0;
    wr_watchdog_ctrl = 1'b0;
    wr_restart = 1'b0;
    wr_event_clear = 1'b0;
    wr_event_enable = 1'b0;
    if (!wr_en_in) begin
      wr_restart = 1'b0;
    end else if (addr_in == WDRTC_OFS_PERIODIC_CTRL) begin
      wr_periodic_ctrl = 1'b1;
    end else if (addr_in == WDRTC_OFS_PERIODIC_FLAG) begin
      wr_periodic_flag = 1'b1;
    end else if (addr_in == WDRTC_OFS_WATCHDOG_CTRL) begin
      wr_watchdog_ctrl = 1'b1;
    end else if (addr_in == WDRTC_OFS_WATCHDOG_RESTART) begin
      wr_restart = 1'b1;
    end else if (addr_in == WDRTC_OFS_EVENT_CLEAR) begin
      wr_event_clear = 1'b1;
    end else if (addr_in == WDRTC_OFS_EVENT_ENABLE) begin
      wr_event_enable = 1'b1;
    end
  end

  // ****************************************
  // Operating mode
  // ****************************************

  // The mode strap is caught while reset is held, so a later change of the pin is ignored.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      special_q <= special_mode_in;
    end
  end

  // Both timers freeze in wait mode only when software asked for it.
  assign halted = stop_in_wait_q && wait_mode_in; // R17

  // ****************************************
  // Periodic control register
  // ****************************************

  // Rate and enable are free to write; stop-in-wait is write once outside special mode.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      periodic_rate_q <= WDRTC_RATE_OFF;
      periodic_irq_enable_q <= 1'b0;
      stop_in_wait_q <= 1'b0;
      divider_bypass_q <= 1'b0;
      periodic_ctrl_written_q <= 1'b0;
    end else if (wr_periodic_ctrl) begin
      periodic_rate_q <= wr_data_in[WDRTC_PC_RATE_HI:WDRTC_PC_RATE_LO]; // R1
      periodic_irq_enable_q <= wr_data_in[WDRTC_PC_IRQ_ENABLE];
      periodic_ctrl_written_q <= 1'b1;
      if (special_q || !periodic_ctrl_written_q) begin
        stop_in_wait_q <= wr_data_in[WDRTC_PC_STOP_IN_WAIT]; // R17
      end
      if (special_q) begin
        divider_bypass_q <= wr_data_in[WDRTC_PC_BYPASS]; // R13
      end
    end
  end

  // ****************************************
  // Periodic timer
  // ****************************************

  // Code one is the base divisor; each further code doubles it.
  assign periodic_shift = PERIODIC_BASE_SHIFT + {2'h0, periodic_rate_q} - 5'h01; // R1

  wdrtc_pow2_timer #(
    .W(WDRTC_PERIODIC_CNT_W)
  ) u_periodic_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .run_in(!halted),
    .clear_in(periodic_rate_q == WDRTC_RATE_OFF),
    .shift_in(periodic_shift),
    .tick_out(periodic_tick)
  );

  // A timeout in the same cycle as a clearing write still leaves the flag set.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      periodic_timeout_flag_q <= 1'b0;
    end else if (periodic_tick) begin
      periodic_timeout_flag_q <= 1'b1; // R2
    end else if (wr_periodic_flag && wr_data_in[WDRTC_PF_TIMEOUT]) begin
      periodic_timeout_flag_q <= 1'b0; // R3
    end
  end

  // ****************************************
  // Watchdog control register
  // ****************************************

  // Special-mode resets come up with system resets disabled.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      clk_monitor_enable_q <= 1'b0;
      force_monitor_enable_q <= 1'b0;
      reset_disable_q <= special_mode_in; // R19
      watchdog_rate_q <= WDRTC_WD_RATE_RESET; // R12
      watchdog_ctrl_written_q <= 1'b0;
    end else if (wr_watchdog_ctrl) begin
      clk_monitor_enable_q <= wr_data_in[WDRTC_WC_MON_ENABLE]; // R5
      watchdog_ctrl_written_q <= 1'b1;
      if (special_q || !watchdog_ctrl_written_q) begin
        force_monitor_enable_q <= wr_data_in[WDRTC_WC_FORCE_MON_ENABLE]; // R6
        watchdog_rate_q <= wr_data_in[WDRTC_WC_RATE_HI:WDRTC_WC_RATE_LO]; // R12
      end
      if (special_q) begin
        reset_disable_q <= wr_data_in[WDRTC_WC_RESET_DISABLE]; // R10
      end
    end
  end

  // Force bits are actions, not storage; outside special mode they are ignored.
  assign force_mon = wr_watchdog_ctrl && special_q && wr_data_in[WDRTC_WC_FORCE_MON_RESET]; // R8
  assign force_wd = wr_watchdog_ctrl && special_q && wr_data_in[WDRTC_WC_FORCE_WD_RESET]; // R9

  // ****************************************
  // Watchdog timer and restart sequence
  // ****************************************

  // Bypass replaces the base stage with its last two stages; the extra division stays.
  assign watchdog_shift = (divider_bypass_q ? WDRTC_BYPASS_SHIFT : WATCHDOG_BASE_SHIFT)
    + wdrtc_wd_extra(watchdog_rate_q); // R11 R13
  assign watchdog_on = (watchdog_rate_q != WDRTC_RATE_OFF); // R11

  assign restart_ok = wr_restart && armed_q && (wr_data_in == WDRTC_RESTART_CODE); // R18
  assign bad_restart = wr_restart && (wr_data_in != WDRTC_ARM_CODE)
    && (wr_data_in != WDRTC_RESTART_CODE); // R16

  wdrtc_pow2_timer #(
    .W(WDRTC_WATCHDOG_CNT_W)
  ) u_watchdog_timer (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .run_in(watchdog_on && !halted),
    .clear_in(restart_ok || !watchdog_on), // R18
    .shift_in(watchdog_shift),
    .tick_out(watchdog_tick)
  );

  // The first step arms the pair; only the matching second step is accepted.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      armed_q <= 1'b0;
    end else if (wr_restart && (wr_data_in == WDRTC_ARM_CODE)) begin
      armed_q <= 1'b1; // R14
    end else if (restart_ok) begin
      armed_q <= 1'b0; // R18
    end
  end

  // ****************************************
  // Clock monitor
  // ****************************************

  // The slow-clock detector is analog and asynchronous, so it is synchronised first.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fail_meta_q <= 1'b0;
      fail_sync_q <= 1'b0;
    end else begin
      fail_meta_q <= clock_fail_in;
      fail_sync_q <= fail_meta_q;
    end
  end

  // Forcing the monitor makes the plain enable irrelevant.
  assign monitor_on = force_monitor_enable_q || clk_monitor_enable_q; // R5 R6

  // ****************************************
  // System reset requests
  // ****************************************

  // Requests are registered; the watchdog request is a one-cycle pulse, the monitor request follows the synchronised fail; the disable bit masks every source.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      watchdog_reset_q <= 1'b0;
      monitor_reset_q <= 1'b0;
    end else begin
      watchdog_reset_q <= !reset_disable_q && watchdog_on
        && (watchdog_tick || bad_restart || force_wd); // R10 R15 R16 R9
      monitor_reset_q <= !reset_disable_q && monitor_on
        && (fail_sync_q || force_mon); // R10 R5 R8
    end
  end

  assign watchdog_reset_out = watchdog_reset_q;
  assign monitor_reset_out = monitor_reset_q;

  // ****************************************
  // Event status, clear and enable
  // ****************************************

  assign event_set = {fail_sync_q && monitor_on,
    watchdog_tick || (bad_restart && watchdog_on), periodic_tick};

  // Sticky events; a new event wins over a clear written in the same cycle.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      event_status_q <= '0;
    end else if (wr_event_clear) begin
      event_status_q <= (event_status_q & ~wr_data_in[WDRTC_EV_WIDTH-1:0]) | event_set;
    end else begin
      event_status_q <= event_status_q | event_set;
    end
  end

  // Interrupt enables for the sticky events.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      event_enable_q <= '0;
    end else if (wr_event_enable) begin
      event_enable_q <= wr_data_in[WDRTC_EV_WIDTH-1:0];
    end
  end

  // The periodic flag has its own enable; the event bank adds its own periodic, watchdog and monitor events.
  assign irq_out = (periodic_timeout_flag_q && periodic_irq_enable_q)
    || (|(event_status_q & event_enable_q)); // R4

  // ****************************************
  // Read port
  // ****************************************

  // Read data are registered and valid only in the cycle after the strobe.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rd_data_q <= WDRTC_READ_ZERO;
    end else if (!rd_en_in) begin
      rd_data_q <= WDRTC_READ_ZERO;
    end else if (addr_in == WDRTC_OFS_PERIODIC_CTRL) begin
      rd_data_q <= WDRTC_READ_ZERO;
      rd_data_q[WDRTC_PC_IRQ_ENABLE] <= periodic_irq_enable_q;
      rd_data_q[WDRTC_PC_STOP_IN_WAIT] <= stop_in_wait_q;
      rd_data_q[WDRTC_PC_BYPASS] <= divider_bypass_q;
      rd_data_q[WDRTC_PC_RATE_HI:WDRTC_PC_RATE_LO] <= periodic_rate_q;
    end else if (addr_in == WDRTC_OFS_PERIODIC_FLAG) begin
      rd_data_q <= WDRTC_READ_ZERO;
      rd_data_q[WDRTC_PF_TIMEOUT] <= periodic_timeout_flag_q; // R2
    end else if (addr_in == WDRTC_OFS_WATCHDOG_CTRL) begin
      rd_data_q <= WDRTC_READ_ZERO;
      rd_data_q[WDRTC_WC_MON_ENABLE] <= clk_monitor_enable_q;
      rd_data_q[WDRTC_WC_FORCE_MON_ENABLE] <= force_monitor_enable_q;
      rd_data_q[WDRTC_WC_RESET_DISABLE] <= reset_disable_q;
      rd_data_q[WDRTC_WC_RATE_HI:WDRTC_WC_RATE_LO] <= watchdog_rate_q;
    end else if (addr_in == WDRTC_OFS_EVENT_STATUS) begin
      rd_data_q <= {{(8-WDRTC_EV_WIDTH){1'b0}}, event_status_q};
    end else if (addr_in == WDRTC_OFS_EVENT_ENABLE) begin
      rd_data_q <= {{(8-WDRTC_EV_WIDTH){1'b0}}, event_enable_q};
    end else begin
      rd_data_q <= WDRTC_READ_ZERO; // R14
    end
  end

  assign rd_data_out = rd_data_q;

endmodule

// ---- logic/wdrtc_pkg.sv ----
// Package of offsets, field layouts, reset values and codes for the watchdog and periodic timer.
package wdrtc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] WDRTC_OFS_PERIODIC_CTRL = 16'h0014;
  localparam logic [15:0] WDRTC_OFS_PERIODIC_FLAG = 16'h0015;
  localparam logic [15:0] WDRTC_OFS_WATCHDOG_CTRL = 16'h0016;
  localparam logic [15:0] WDRTC_OFS_WATCHDOG_RESTART = 16'h0017;
  localparam logic [15:0] WDRTC_OFS_EVENT_STATUS = 16'h0018;
  localparam logic [15:0] WDRTC_OFS_EVENT_CLEAR = 16'h0019;
  localparam logic [15:0] WDRTC_OFS_EVENT_ENABLE = 16'h001A;

  // ****************************************
  // Periodic control field positions
  // ****************************************
  localparam int WDRTC_PC_IRQ_ENABLE = 7;
  localparam int WDRTC_PC_STOP_IN_WAIT = 6;
  localparam int WDRTC_PC_BYPASS = 3;
  localparam int WDRTC_PC_RATE_HI = 2;
  localparam int WDRTC_PC_RATE_LO = 0;

  // Periodic flag register field position.
  localparam int WDRTC_PF_TIMEOUT = 7;

  // ****************************************
  // Watchdog control field positions
  // ****************************************
  localparam int WDRTC_WC_MON_ENABLE = 7;
  localparam int WDRTC_WC_FORCE_MON_ENABLE = 6;
  localparam int WDRTC_WC_FORCE_MON_RESET = 5;
  localparam int WDRTC_WC_FORCE_WD_RESET = 4;
  localparam int WDRTC_WC_RESET_DISABLE = 3;
  localparam int WDRTC_WC_RATE_HI = 2;
  localparam int WDRTC_WC_RATE_LO = 0;

  // Event status bit positions.
  localparam int WDRTC_EV_PERIODIC = 0;
  localparam int WDRTC_EV_WATCHDOG = 1;
  localparam int WDRTC_EV_MONITOR = 2;
  localparam int WDRTC_EV_WIDTH = 3;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [2:0] WDRTC_RATE_OFF = 3'h0;
  localparam logic [2:0] WDRTC_WD_RATE_RESET = 3'h1;
  localparam logic [7:0] WDRTC_ARM_CODE = 8'h55;
  localparam logic [7:0] WDRTC_RESTART_CODE = 8'hAA;
  localparam logic [7:0] WDRTC_READ_ZERO = 8'h00;

  // Divider stages kept by the bypass test bit.
  localparam logic [4:0] WDRTC_BYPASS_SHIFT = 5'h02;
  localparam int WDRTC_PERIODIC_CNT_W = 19;
  localparam int WDRTC_WATCHDOG_CNT_W = 23;

  // Extra watchdog division beyond the base stage, as a power of two, per rate code.
  function automatic logic [4:0] wdrtc_wd_extra(input logic [2:0] code);
    logic [4:0] extra;
    extra = 5'h00;
    case (code)
      3'h1: extra = 5'h00;
      3'h2: extra = 5'h02;
      3'h3: extra = 5'h04;
      3'h4: extra = 5'h06;
      3'h5: extra = 5'h08;
      3'h6: extra = 5'h09;
      3'h7: extra = 5'h0A;
      default: extra = 5'h00;
    endcase
    return extra;
  endfunction

endpackage

// ---- logic/wdrtc_pow2_timer.sv ----
// Power-of-two timeout counter that ticks once every 2^shift running cycles.
`timescale 1ns/1ns
module wdrtc_pow2_timer #(
  parameter int W = 19
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [4:0] shift_in,
  output logic tick_out
);

  logic [W-1:0] count_q;
  logic [W-1:0] limit;

  // Terminal count is 2^shift - 1; the extra bit keeps the shift from overflowing.
  assign limit = W'(({{W{1'b0}}, 1'b1} << shift_in) - 1'b1);
  assign tick_out = run_in && !clear_in && (count_q == limit);

  // Counter wraps at the terminal count; a clear restarts the full period.
  always_ff @(posedge clock_in) begin
    if (reset_in || clear_in) begin
      count_q <= '0;
    end else if (run_in) begin
      if (count_q == limit) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

endmodule

// ---- testbench/wdrtc_top_sva.sv ----
// Concurrent checks on the ports of the watchdog, periodic timer and monitor block.
`timescale 1ns/1ns
module wdrtc_top_sva (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic special_mode_in,
  input wire logic wait_mode_in,
  input wire logic clock_fail_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic irq_out,
  input wire logic watchdog_reset_out,
  input wire logic monitor_reset_out
);
  import wdrtc_pkg::*;
  logic special_q;
  logic once_q;
  logic [7:0] ctrl_q;
  logic wr_ctrl;
  logic wr_rst;
  logic bad_byte;
  logic mon_on;
  // ****************************************
  // Shadow of the watchdog control register
  // ****************************************
  // The checks need the live enables, so the write rules are mirrored here.
  assign wr_ctrl = wr_en_in && addr_in == WDRTC_OFS_WATCHDOG_CTRL;
  assign wr_rst = wr_en_in && addr_in == WDRTC_OFS_WATCHDOG_RESTART;
  assign bad_byte = wr_rst && wr_data_in != WDRTC_ARM_CODE && wr_data_in != WDRTC_RESTART_CODE;
  assign mon_on = ctrl_q[7] | ctrl_q[6];
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      special_q <= special_mode_in;
      once_q <= 1'b0;
      ctrl_q <= {4'h0, special_mode_in, 3'h1};
    end else if (wr_ctrl) begin
      once_q <= 1'b1;
      if (special_q) begin
        ctrl_q <= wr_data_in & 8'hCF;
      end else if (!once_q) begin
        ctrl_q <= {wr_data_in[7:6], 3'h0, wr_data_in[2:0]};
      end else begin
        ctrl_q[7] <= wr_data_in[7];
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence arm_s;
    wr_rst && wr_data_in == WDRTC_ARM_CODE;
  endsequence
  sequence pair_s;
    arm_s ##[1:8] (wr_rst && wr_data_in == WDRTC_RESTART_CODE);
  endsequence
  rd_idle_zero_a: assert property (!rd_en_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
  flag_low_zero_a: assert property (
    rd_en_in && addr_in == WDRTC_OFS_PERIODIC_FLAG |=> rd_data_out[6:0] == 7'h00)
    else $error("flag register low bits not zero");
  restart_reads_zero_a: assert property (
    rd_en_in && addr_in == WDRTC_OFS_WATCHDOG_RESTART |=> rd_data_out == 8'h00)
    else $error("restart register read not zero");
  bad_byte_reset_a: assert property (
    bad_byte && ctrl_q[2:0] != 3'h0 && !ctrl_q[3] |=> watchdog_reset_out)
    else $error("bad restart byte gave no watchdog reset");
  force_wd_reset_a: assert property (
    wr_ctrl && special_q && wr_data_in[4] && !wr_data_in[3] && !ctrl_q[3]
    && wr_data_in[2:0] != 3'h0 && ctrl_q[2:0] != 3'h0 |=> watchdog_reset_out)
    else $error("forced watchdog reset missing");
  force_mon_reset_a: assert property (
    wr_ctrl && special_q && wr_data_in[5] && wr_data_in[7] && !wr_data_in[3] && !ctrl_q[3]
    && mon_on |=> monitor_reset_out)
    else $error("forced monitor reset missing");
  reset_disable_block_a: assert property (
    ctrl_q[3] && $past(ctrl_q[3]) |-> !watchdog_reset_out && !monitor_reset_out)
    else $error("system reset while resets disabled");
  wd_off_quiet_a: assert property (
    ctrl_q[2:0] == 3'h0 && $past(ctrl_q[2:0]) == 3'h0 && $past(ctrl_q[2:0], 2) == 3'h0
    |-> !watchdog_reset_out)
    else $error("watchdog reset while watchdog off");
  monitor_fail_a: assert property (
    (clock_fail_in && mon_on && !ctrl_q[3])[*4] |=> monitor_reset_out)
    else $error("clock failure gave no monitor reset");
  restart_quiet_a: assert property (
    pair_s ##1 !wr_en_in |-> (!watchdog_reset_out)[*2])
    else $error("watchdog reset right after restart pair");
endmodule
bind wdrtc_top wdrtc_top_sva i_wdrtc_top_sva (.clock_in(clock_in), .reset_in(reset_in),
  .special_mode_in(special_mode_in), .wait_mode_in(wait_mode_in),
  .clock_fail_in(clock_fail_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
  .watchdog_reset_out(watchdog_reset_out), .monitor_reset_out(monitor_reset_out));

// ---- testbench/wdrtc_top_test.sv ----
// Self-checking bench for the watchdog, periodic timer and clock monitor block.
`timescale 1ns/1ns
module wdrtc_top_test;
  import wdrtc_pkg::*;
  logic clock_in, reset_in, special_mode_in, wait_mode_in, clock_fail_in;
  logic [15:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out, d;
  logic wr_en_in, rd_en_in, irq_out, watchdog_reset_out, monitor_reset_out;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h1D;
  // Short base shifts keep the longest watchdog period near eight thousand cycles.
  wdrtc_top #(.PERIODIC_BASE_SHIFT(5'h02), .WATCHDOG_BASE_SHIFT(5'h03)) i_wdrtc_top (
    .clock_in(clock_in), .reset_in(reset_in), .special_mode_in(special_mode_in),
    .wait_mode_in(wait_mode_in), .clock_fail_in(clock_fail_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out), .watchdog_reset_out(watchdog_reset_out),
    .monitor_reset_out(monitor_reset_out));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected cycles from count start to a visible event.
  function automatic int rti_period(input int r);
    return 1 << (r + 1);
  endfunction
  function automatic int wd_period(input int r, input int base);
    return 1 << (base + (r < 6 ? 2 * r - 2 : r + 3));
  endfunction
  function automatic logic pick(input int s);
    return s == 0 ? irq_out : (s == 1 ? watchdog_reset_out : monitor_reset_out);
  endfunction
  task automatic stop_test();
    $display("Checks made: %0d, mismatches: %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
    // Callers look at outputs next, so step past the edge that applies the write.
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string name);
    @(posedge clock_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    check(name, e, rd_data_out);
  endtask
  // Counts edges until the chosen output is high, giving up at the limit.
  task automatic wait_for(input int s, input int lim);
    n = 0;
    #1;
    while (n < lim && pick(s) !== 1'b1) begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask
  task automatic pair();
    wr(WDRTC_OFS_WATCHDOG_RESTART, 8'h55);
    wr(WDRTC_OFS_WATCHDOG_RESTART, 8'hAA);
  endtask
  task automatic do_reset(input logic mode);
    @(posedge clock_in);
    reset_in <= 1'b1;
    special_mode_in <= mode;
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
  endtask
  // ****************************************
  // Clock, watchdog on the run, main sequence
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // A hang is cut short well past the longest expected run.
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    reset_in = 1'b1;
    special_mode_in = 1'b0;
    wait_mode_in = 1'b0;
    clock_fail_in = 1'b0;
    addr_in = 16'h0000;
    wr_data_in = 8'h00;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    do_reset(1'b0);
    rd(WDRTC_OFS_WATCHDOG_CTRL, 8'h01, "normal ctrl reset");
    rd(WDRTC_OFS_PERIODIC_FLAG, 8'h00, "flag reset");
    rd(WDRTC_OFS_WATCHDOG_RESTART, 8'h00, "restart read");
    rd(16'h0030, 8'h00, "unmapped read");
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h78);
    rd(WDRTC_OFS_WATCHDOG_CTRL, 8'h40, "ctrl first write");
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h0D);
    rd(WDRTC_OFS_WATCHDOG_CTRL, 8'h40, "ctrl write once");
    @(posedge clock_in);
    clock_fail_in <= 1'b1;
    wait_for(2, 8);
    check("monitor fail reset", 1, n < 8);
    repeat (6) @(posedge clock_in);
    clock_fail_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    wr(WDRTC_OFS_PERIODIC_CTRL, 8'h40);
    for (int r = 1; r < 8; r++) begin
      wr(WDRTC_OFS_PERIODIC_CTRL, 8'h40);
      wr(WDRTC_OFS_PERIODIC_FLAG, 8'h80);
      wr(WDRTC_OFS_PERIODIC_CTRL, {5'h18, r[2:0]});
      wait_for(0, 300);
      check("periodic period", 1, n >= rti_period(r) - 1 && n <= rti_period(r) + 1);
      rd(WDRTC_OFS_PERIODIC_FLAG, 8'h80, "flag set");
    end
    wr(WDRTC_OFS_PERIODIC_FLAG, 8'h7F);
    rd(WDRTC_OFS_PERIODIC_FLAG, 8'h80, "flag kept on zero write");
    // Rate zero also clears the count, so the rate-one run after wait starts from zero.
    wr(WDRTC_OFS_PERIODIC_CTRL, 8'h40);
    check("irq masked", 0, irq_out);
    wr(WDRTC_OFS_PERIODIC_FLAG, 8'h80);
    @(posedge clock_in);
    wait_mode_in <= 1'b1;
    wr(WDRTC_OFS_PERIODIC_CTRL, 8'hC1);
    wait_for(0, 40);
    check("halted in wait", 40, n);
    @(posedge clock_in);
    wait_mode_in <= 1'b0;
    wait_for(0, 20);
    check("runs after wait", 1, n < 20);
    wr(WDRTC_OFS_PERIODIC_CTRL, 8'h00);
    wr(WDRTC_OFS_PERIODIC_FLAG, 8'h80);
    rd(WDRTC_OFS_EVENT_STATUS, 8'h07, "event status");
    wr(WDRTC_OFS_EVENT_ENABLE, 8'h02);
    check("event irq", 1, irq_out);
    wr(WDRTC_OFS_EVENT_ENABLE, 8'h00);
    check("event irq masked", 0, irq_out);
    wr(WDRTC_OFS_EVENT_ENABLE, 8'h02);
    wr(WDRTC_OFS_EVENT_CLEAR, 8'h07);
    rd(WDRTC_OFS_EVENT_STATUS, 8'h00, "event cleared");
    check("event irq cleared", 0, irq_out);
    do_reset(1'b1);
    rd(WDRTC_OFS_WATCHDOG_CTRL, 8'h09, "special ctrl reset");
    wait_for(1, 40);
    check("resets disabled", 40, n);
    wr(WDRTC_OFS_WATCHDOG_RESTART, 8'h33);
    wait_for(1, 5);
    check("bad byte disabled", 5, n);
    for (int r = 1; r < 8; r++) begin
      wr(WDRTC_OFS_WATCHDOG_CTRL, {5'h01, r[2:0]});
      pair();
      wr(WDRTC_OFS_WATCHDOG_CTRL, {5'h00, r[2:0]});
      wait_for(1, 9000);
      check("watchdog period", 1, n >= wd_period(r, 3) - 3 && n <= wd_period(r, 3) + 2);
    end
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h02);
    for (int i = 0; i < 6; i++) begin
      wr(WDRTC_OFS_WATCHDOG_RESTART, 8'h55);
      wr(16'h0030, 8'(xorshift()));
      wr(WDRTC_OFS_WATCHDOG_RESTART, 8'hAA);
      wait_for(1, 16);
      check("serviced no reset", 16, n);
    end
    d = 8'(xorshift());
    if (d == 8'h55 || d == 8'hAA) begin
      d = 8'h00;
    end
    wr(WDRTC_OFS_WATCHDOG_RESTART, d);
    wait_for(1, 3);
    check("bad byte reset", 1, n < 3);
    pair();
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h12);
    wait_for(1, 3);
    check("forced watchdog reset", 1, n < 3);
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h0A);
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h1A);
    wait_for(1, 30);
    check("forced reset disabled", 30, n);
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h82);
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'hA2);
    wait_for(2, 3);
    check("forced monitor reset", 1, n < 3);
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h09);
    wr(WDRTC_OFS_PERIODIC_CTRL, 8'h08);
    pair();
    wr(WDRTC_OFS_WATCHDOG_CTRL, 8'h01);
    wait_for(1, 40);
    check("bypass period", 1, n >= 1 && n <= 6);
    stop_test();
  end
endmodule
